// ### tts_ctrl.sv
`timescale 1ns/10ps
`include "tts_defines.svh"
// Behaviour
// - Test mode follows the remote test lead, on while it is on and off when it drops.
// - In test mode the data source and data sync sides are cut off and request-to-send is ignored.
// - In test mode the received group data is looped onto the transmit group data.
// - In test mode request-to-send is forced on and send-character follows character-present.
// - Each character is sent as one low tone and one high tone picked by the active lead of each group.
// - A group with more than one active lead sends no data tone, only its rest tone.
// - Tones reach the line only while send-character and request-to-send are both on.
// - Received tones are sorted into low, high and C bands by frequency.
// - A character is valid only with exactly one low and exactly one high indicator active.
// - Character-present is on only for a valid received character and off otherwise.
// - Receive outputs rest at zero without data, and each character shows for 40 ms.
// - In test mode only, steady C0 tone enables validity testing and steady C1 tone enables frequency checks.
// - With power lost every control input counts as off.
// - Internal send-character stays on while the input is on and at least 50 ms from its rise.
// - Low tones are 697, 770, 852 and 941 Hz with a 600 Hz rest tone.
module tts_ctrl
	import tts_pkg::*;
#(
	parameter int TICK_CYC = `TTS_CLK_KHZ * `TTS_TICK_MS,
	parameter int DEB_MS   = `TTS_DEB_MS,
	parameter int DEPTH    = `TTS_FIFO_DEPTH
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        power_ok,
	input  wire logic        send_character,
	input  wire logic        request_to_send,
	input  wire logic        remote_test_lead,
	input  wire logic [3:0]  tx_low_lead,
	input  wire logic [3:0]  tx_high_lead,
	input  wire logic [3:0]  rx_low_det,
	input  wire logic [3:0]  rx_high_det,
	input  wire logic        rx_c0_det,
	input  wire logic        rx_c1_det,
	input  wire logic        rx_tone_on,
	input  wire logic [11:0] rx_tone_hz,
	output logic             test_mode,
	output logic             data_source_interface_en,
	output logic             data_sync_interface_en,
	output logic             tx_line_en,
	output logic [11:0]      tx_low_hz,
	output logic [11:0]      tx_high_hz,
	output logic [3:0]       rx_low_data,
	output logic [3:0]       rx_high_data,
	output logic             character_present,
	output logic             c0_validity_test_en,
	output logic             c1_freq_check_en,
	output tts_band_t        rx_band
);
	localparam int          TW       = $clog2(TICK_CYC);
	localparam logic [5:0]  CP_TICKS = 6'(`TTS_CP_PULSE_MS / `TTS_TICK_MS);
	localparam logic [5:0]  SC_TICKS = 6'(`TTS_SC_MIN_MS / `TTS_TICK_MS);

	function automatic logic tts_one_hot(input logic [3:0] v);
		return $onehot(v);
	endfunction : tts_one_hot

	function automatic logic [11:0] tts_tone_hz(input logic [3:0] lead, input logic hi);
		logic [11:0] hz;
		hz = hi ? `TTS_HIGH_REST_HZ : `TTS_LOW_REST_HZ;
		if (tts_one_hot(lead)) begin
			case (lead)
				4'h1:    hz = hi ? `TTS_HIGH_1_HZ : `TTS_LOW_1_HZ;
				4'h2:    hz = hi ? `TTS_HIGH_2_HZ : `TTS_LOW_2_HZ;
				4'h4:    hz = hi ? `TTS_HIGH_3_HZ : `TTS_LOW_3_HZ;
				4'h8:    hz = hi ? `TTS_HIGH_4_HZ : `TTS_LOW_4_HZ;
				default: hz = hi ? `TTS_HIGH_REST_HZ : `TTS_LOW_REST_HZ;
			endcase
		end
		return hz;
	endfunction : tts_tone_hz

	function automatic tts_band_t tts_band(input logic on, input logic [11:0] hz);
		tts_band_t b;
		b = TTS_BAND_NONE;
		if (on && hz >= `TTS_LOW_MIN_HZ && hz <= `TTS_LOW_MAX_HZ) begin
			b = TTS_BAND_LOW;
		end else if (on && hz >= `TTS_HIGH_MIN_HZ && hz <= `TTS_HIGH_MAX_HZ) begin
			b = TTS_BAND_HIGH;
		end else if (on && hz >= `TTS_C_MIN_HZ && hz <= `TTS_C_MAX_HZ) begin
			b = TTS_BAND_C;
		end
		return b;
	endfunction : tts_band

	// ==========================================================
	// millisecond tick
	// ==========================================================
	logic [TW-1:0] div_r;
	logic          tick_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else if (div_r == TW'(TICK_CYC - 1)) begin
			div_r  <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + TW'(1);
			tick_r <= 1'b0;
		end
	end

	// ==========================================================
	// input conditioning
	// ==========================================================
	logic [12:0] filt_in;
	logic [12:0] filt_out;
	logic        sc_f;
	logic        rts_f;
	logic        rt_f;
	tts_code_t   det_f;
	logic        c0_f;
	logic        c1_f;
	tts_code_t   lead_r;

	assign filt_in = power_ok ? {rx_c1_det, rx_c0_det, rx_high_det, rx_low_det,
		remote_test_lead, request_to_send, send_character} : 13'h0000;
	assign {c1_f, c0_f, det_f, rt_f, rts_f, sc_f} = filt_out;

	tts_filt #(
		.W (`TTS_FILT_W),
		.N (DEB_MS)
	) u_filt (
		.clk  (clk),
		.rstn (rstn),
		.tick (tick_r),
		.din  (filt_in),
		.dout (filt_out)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lead_r <= `TTS_CODE_RST;
		end else begin
			lead_r <= power_ok ? {tx_high_lead, tx_low_lead} : `TTS_CODE_RST;
		end
	end

	// ==========================================================
	// test mode and loopback
	// ==========================================================
	logic      test_r;
	logic      rts_eff;
	logic      sc_eff;
	tts_code_t tx_eff;
	tts_code_t rx_code_r;
	logic      cp_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			test_r <= 1'b0;
		end else begin
			test_r <= rt_f;
		end
	end

	assign test_mode                = test_r;
	assign data_source_interface_en = !test_r;
	assign data_sync_interface_en   = !test_r;
	// force rts, loop cp to sc
	assign rts_eff                  = test_r ? 1'b1 : rts_f;
	assign sc_eff                   = test_r ? cp_r : sc_f;
	assign tx_eff                   = test_r ? rx_code_r : lead_r;

	// ==========================================================
	// send-character stretch
	// ==========================================================
	logic       sc_d_r;
	logic       mono_r;
	logic [5:0] mono_cnt_r;
	logic       sc_int;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sc_d_r     <= 1'b0;
			mono_r     <= 1'b0;
			mono_cnt_r <= 6'h00;
		end else begin
			sc_d_r <= sc_eff;
			if (sc_eff && !sc_d_r) begin
				mono_r     <= 1'b1;
				mono_cnt_r <= 6'h00;
			end else if (mono_r && tick_r) begin
				if (mono_cnt_r == SC_TICKS - 6'h01) begin
					mono_r <= 1'b0;
				end
				mono_cnt_r <= mono_cnt_r + 6'h01;
			end
		end
	end

	assign sc_int = sc_eff || mono_r;

	assign tx_line_en = power_ok && sc_int && rts_eff;

	// ==========================================================
	// transmit tone selection
	// ==========================================================
	// one tone per group
	// clashing leads fall back to rest
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_low_hz  <= `TTS_LOW_REST_HZ;
			tx_high_hz <= `TTS_HIGH_REST_HZ;
		end else begin
			tx_low_hz  <= tts_tone_hz(tx_eff.low, 1'b0);
			tx_high_hz <= tts_tone_hz(tx_eff.high, 1'b1);
		end
	end

	// ==========================================================
	// receive band sorting and c channel
	// ==========================================================
	// classify by frequency
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_band <= TTS_BAND_NONE;
		end else begin
			rx_band <= tts_band(rx_tone_on && power_ok, rx_tone_hz);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			c0_validity_test_en <= 1'b0;
			c1_freq_check_en    <= 1'b0;
		end else begin
			c0_validity_test_en <= test_r && c0_f;
			c1_freq_check_en    <= test_r && c1_f;
		end
	end

	// ==========================================================
	// validity check and character capture
	// ==========================================================
	logic      valid;
	logic      valid_d_r;
	logic      pend_r;
	tts_code_t pend_code_r;
	logic      in_ready;
	logic      out_valid;
	logic      out_ready;
	tts_code_t out_code;

	assign valid = tts_one_hot(det_f.low) && tts_one_hot(det_f.high);

	// a new character overwrites one still waiting when the fifo is full
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			valid_d_r   <= 1'b0;
			pend_r      <= 1'b0;
			pend_code_r <= `TTS_CODE_RST;
		end else begin
			valid_d_r <= valid;
			if (valid && !valid_d_r) begin
				pend_r      <= 1'b1;
				pend_code_r <= det_f;
			end else if (in_ready) begin
				pend_r <= 1'b0;
			end
		end
	end

	tts_fifo #(
		.W     (`TTS_CODE_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (pend_r),
		.in_ready  (in_ready),
		.in_data   (pend_code_r),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_code)
	);

	// ==========================================================
	// receive output timing
	// ==========================================================
	tts_state_t st_r;
	logic [5:0] show_cnt_r;

	assign out_ready = (st_r == TTS_ST_IDLE);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r       <= TTS_ST_IDLE;
			show_cnt_r <= 6'h00;
		end else begin
			case (st_r)
				TTS_ST_IDLE: begin
					show_cnt_r <= 6'h00;
					if (out_valid) begin
						st_r <= TTS_ST_SHOW;
					end
				end
				TTS_ST_SHOW: begin
					if (tick_r) begin
						show_cnt_r <= show_cnt_r + 6'h01;
						if (show_cnt_r == CP_TICKS - 6'h01) begin
							st_r <= TTS_ST_GAP;
						end
					end
				end
				TTS_ST_GAP: begin
					// one tick low keeps back-to-back characters apart
					if (tick_r) begin
						st_r <= TTS_ST_IDLE;
					end
				end
				default: st_r <= TTS_ST_IDLE;
			endcase
		end
	end

	// present only with a valid character held
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_code_r <= `TTS_CODE_RST;
			cp_r      <= 1'b0;
		end else if (st_r == TTS_ST_IDLE && out_valid) begin
			rx_code_r <= out_code;
			cp_r      <= 1'b1;
		end else if (st_r != TTS_ST_SHOW) begin
			rx_code_r <= `TTS_CODE_RST;
			cp_r      <= 1'b0;
		end
	end

	assign character_present = cp_r;

	// data sync side sees nothing in test
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_low_data  <= 4'h0;
			rx_high_data <= 4'h0;
		end else begin
			rx_low_data  <= test_r ? 4'h0 : rx_code_r.low;
			rx_high_data <= test_r ? 4'h0 : rx_code_r.high;
		end
	end

	// ==========================================================
	// checks
	// ==========================================================
	sequence sc_rise_s;
		sc_eff && !sc_d_r ##1 mono_r;
	endsequence

	test_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		rt_f != test_r |=> test_r == $past(rt_f))
		else $error("test mode did not follow remote test lead");

	test_iso_a: assert property (@(posedge clk) disable iff (!rstn)
		test_r |-> (!data_source_interface_en && !data_sync_interface_en)
			##1 (rx_low_data == 4'h0 && rx_high_data == 4'h0))
		else $error("customer side not isolated in test");

	loop_path_a: assert property (@(posedge clk) disable iff (!rstn)
		test_r |=> tx_low_hz == tts_tone_hz($past(rx_code_r.low), 1'b0))
		else $error("loopback data not transmitted");

	test_force_a: assert property (@(posedge clk) disable iff (!rstn)
		test_r && cp_r && power_ok |-> tx_line_en)
		else $error("test mode did not force line on");

	tone_pick_a: assert property (@(posedge clk) disable iff (!rstn)
		tx_eff.high == 4'h8 |=> tx_high_hz == `TTS_HIGH_4_HZ)
		else $error("wrong high tone chosen");

	tone_clash_a: assert property (@(posedge clk) disable iff (!rstn)
		tx_eff.low == 4'h3 |=> tx_low_hz == `TTS_LOW_REST_HZ)
		else $error("clashing leads produced a data tone");

	line_gate_a: assert property (@(posedge clk) disable iff (!rstn)
		tx_line_en |-> sc_int && rts_eff && power_ok)
		else $error("line enabled without both controls");

	band_sort_a: assert property (@(posedge clk) disable iff (!rstn)
		rx_tone_on && power_ok && rx_tone_hz == `TTS_C_MIN_HZ |=> rx_band == TTS_BAND_C)
		else $error("tone sorted into wrong band");

	cp_valid_a: assert property (@(posedge clk) disable iff (!rstn)
		cp_r |-> $onehot(rx_code_r.low) && $onehot(rx_code_r.high))
		else $error("character present without valid code");

	cp_len_a: assert property (@(posedge clk) disable iff (!rstn)
		$fell(cp_r) |-> $past(st_r) == TTS_ST_GAP && $past(show_cnt_r) == CP_TICKS)
		else $error("character present pulse length wrong");

	c_chan_a: assert property (@(posedge clk) disable iff (!rstn)
		test_r && c1_f |=> c1_freq_check_en)
		else $error("c1 tone did not enable frequency check");

	sc_min_a: assert property (@(posedge clk) disable iff (!rstn)
		sc_rise_s |-> sc_int [*8])
		else $error("send character not stretched");

endmodule : tts_ctrl

// ### tts_defines.svh
`ifndef TTS_DEFINES_SVH
`define TTS_DEFINES_SVH

// ==========================================================
// timing, in the unit as printed
// ==========================================================
`define TTS_CLK_KHZ        25000
`define TTS_TICK_MS        1
`define TTS_CP_PULSE_MS    40
`define TTS_SC_MIN_MS      50
`define TTS_DEB_MS         3

// ==========================================================
// tone frequencies in hz
// ==========================================================
`define TTS_LOW_REST_HZ    12'h258
`define TTS_LOW_1_HZ       12'h2b9
`define TTS_LOW_2_HZ       12'h302
`define TTS_LOW_3_HZ       12'h354
`define TTS_LOW_4_HZ       12'h3ad
`define TTS_HIGH_REST_HZ   12'h44a
`define TTS_HIGH_1_HZ      12'h4b9
`define TTS_HIGH_2_HZ      12'h538
`define TTS_HIGH_3_HZ      12'h5c5
`define TTS_HIGH_4_HZ      12'h661

// ==========================================================
// receive band limits in hz
// ==========================================================
`define TTS_LOW_MIN_HZ     12'h258
`define TTS_LOW_MAX_HZ     12'h3ad
`define TTS_HIGH_MIN_HZ    12'h44a
`define TTS_HIGH_MAX_HZ    12'h661
`define TTS_C_MIN_HZ       12'h79e
`define TTS_C_MAX_HZ       12'h8ca

// ==========================================================
// sizes and reset values
// ==========================================================
`define TTS_FIFO_DEPTH     8
`define TTS_CODE_W         8
`define TTS_FILT_W         13
`define TTS_CODE_RST       8'h00

`endif

// ### tts_pkg.sv
package tts_pkg;

	typedef struct packed {
		logic [3:0] high;
		logic [3:0] low;
	} tts_code_t;

	typedef enum logic [3:0] {
		TTS_BAND_NONE = 4'h1,
		TTS_BAND_LOW  = 4'h2,
		TTS_BAND_HIGH = 4'h4,
		TTS_BAND_C    = 4'h8
	} tts_band_t;

	typedef enum logic [2:0] {
		TTS_ST_IDLE = 3'h1,
		TTS_ST_SHOW = 3'h2,
		TTS_ST_GAP  = 3'h4
	} tts_state_t;

endpackage : tts_pkg

// ### tts_fifo.sv
`timescale 1ns/10ps
module tts_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr_r;
	logic [AW:0]  rd_ptr_r;
	logic         push;
	logic         pop;

	// extra pointer bit tells full from empty
	assign in_ready  = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) || (wr_ptr_r[AW] == rd_ptr_r[AW]);
	assign out_valid = (wr_ptr_r != rd_ptr_r);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_r[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_r <= '0;
		end else if (push) begin
			wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_ptr_r <= '0;
		end else if (pop) begin
			rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
		end
	end

endmodule : tts_fifo

// ### tts_filt.sv
`timescale 1ns/10ps
module tts_filt #(
	parameter int W = 13,
	parameter int N = 3
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         tick,
	input  wire logic [W-1:0] din,
	output logic [W-1:0]      dout
);
	logic [W-1:0] sync1_r;
	logic [W-1:0] sync2_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= din;
			sync2_r <= sync1_r;
		end
	end

	// ==========================================================
	// per-bit stability filter
	// ==========================================================
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic [3:0] cnt_r;
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				cnt_r   <= 4'h0;
				dout[i] <= 1'b0;
			end else if (sync2_r[i] == dout[i]) begin
				cnt_r <= 4'h0;
			end else if (tick) begin
				if (cnt_r == 4'(N - 1)) begin
					dout[i] <= sync2_r[i];
					cnt_r   <= 4'h0;
				end else begin
					cnt_r <= cnt_r + 4'h1;
				end
			end
		end
	end

	filt_tick_a: assert property (@(posedge clk) disable iff (!rstn)
		(dout != $past(dout)) |-> $past(tick))
		else $error("filtered input changed without a tick");

endmodule : tts_filt

// ### tts_peer.sv
`timescale 1ns/10ps
// ==========================================================
// associated data source and telephone control equipment
// ==========================================================
module tts_peer (
	input  wire logic       clk,
	input  wire logic       want_send,
	input  wire logic       line_grant,
	input  wire logic [3:0] low_sel,
	input  wire logic [3:0] high_sel,
	output logic            send_character,
	output logic            request_to_send,
	output logic [3:0]      tx_low_lead,
	output logic [3:0]      tx_high_lead
);
	initial begin
		send_character = 1'b0;
		request_to_send = 1'b0;
		tx_low_lead = 4'h0;
		tx_high_lead = 4'h0;
	end
	// leads move on the falling edge, away from the sampling edge
	always @(negedge clk) begin
		tx_low_lead <= low_sel;
		tx_high_lead <= high_sel;
		request_to_send <= line_grant;
		send_character <= want_send;
	end
endmodule : tts_peer

// ### tts_tb.sv
`timescale 1ns/10ps
module tb;
	import tts_pkg::*;
	localparam int TK = 10;
	logic        clk, rstn, power_ok, want_send, grant, rt, c0, c1, tone_on;
	logic [3:0]  lo_sel, hi_sel, rx_lo, rx_hi, txl, txh, rxl_d, rxh_d;
	logic [11:0] tone_hz, lo_hz, hi_hz;
	logic        sc, rts, test_mode, src_en, sync_en, line_en, cp, c0_en, c1_en;
	tts_band_t   band;
	int          num_errors, n_checks, cyc;
	logic [11:0] low_tab [4]  = '{12'h2b9, 12'h302, 12'h354, 12'h3ad};
	logic [11:0] high_tab [4] = '{12'h4b9, 12'h538, 12'h5c5, 12'h661};
	logic [11:0] hz_tab [8]   = '{12'h258, 12'h3ad, 12'h44a, 12'h661, 12'h79e, 12'h8ca, 12'h3e8, 12'h8fc};
	logic [3:0]  band_tab [8] = '{4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8, 4'h1, 4'h1};

	tts_peer u_peer (.clk(clk), .want_send(want_send), .line_grant(grant), .low_sel(lo_sel), .high_sel(hi_sel),
		.send_character(sc), .request_to_send(rts), .tx_low_lead(txl), .tx_high_lead(txh));
	tts_ctrl #(.TICK_CYC(TK), .DEB_MS(2), .DEPTH(8)) u_dut (.clk(clk), .rstn(rstn), .power_ok(power_ok),
		.send_character(sc), .request_to_send(rts), .remote_test_lead(rt), .tx_low_lead(txl),
		.tx_high_lead(txh), .rx_low_det(rx_lo), .rx_high_det(rx_hi), .rx_c0_det(c0), .rx_c1_det(c1),
		.rx_tone_on(tone_on), .rx_tone_hz(tone_hz), .test_mode(test_mode), .data_source_interface_en(src_en),
		.data_sync_interface_en(sync_en), .tx_line_en(line_en), .tx_low_hz(lo_hz), .tx_high_hz(hi_hz),
		.rx_low_data(rxl_d), .rx_high_data(rxh_d), .character_present(cp), .c0_validity_test_en(c0_en),
		.c1_freq_check_en(c1_en), .rx_band(band));

	// ==========================================================
	// clock, timeout and reporting
	// ==========================================================
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			give_verdict;
		end
	end
	task give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	task chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task chk_val(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val
	// debounce needs a few ticks of agreement
	task settle;
		repeat (50) @(negedge clk);
	endtask : settle
	task wait_cp;
		for (int w = 0; w < 200 && cp !== 1'b1; w++) @(negedge clk);
	endtask : wait_cp
	task quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge clk);
			if (cp !== 1'b0) seen = 1'b1;
		end
		chk_bit(seen, 1'b0);
	endtask : quiet

	// ==========================================================
	// scenarios
	// ==========================================================
	task t_reset;
		chk_val(lo_hz, 12'h258);
		chk_val(hi_hz, 12'h44a);
		chk_val(band, 12'h001);
		chk_bit(cp, 1'b0);
		chk_val(rxl_d, 12'h000);
		chk_bit(line_en, 1'b0);
		chk_bit(src_en, 1'b1);
	endtask : t_reset
	task t_tones;
		for (int k = 0; k < 4; k++) begin
			lo_sel = 4'h1 << k;
			hi_sel = 4'h1 << k;
			repeat (4) @(negedge clk);
			chk_val(lo_hz, low_tab[k]);
			chk_val(hi_hz, high_tab[k]);
		end
		lo_sel = 4'h5;
		hi_sel = 4'hc;
		repeat (4) @(negedge clk);
		chk_val(lo_hz, 12'h258);
		chk_val(hi_hz, 12'h44a);
		lo_sel = 4'h0;
		hi_sel = 4'h0;
	endtask : t_tones
	task t_line;
		grant = 1'b1;
		settle;
		chk_bit(line_en, 1'b0);
		want_send = 1'b1;
		settle;
		chk_bit(line_en, 1'b1);
		power_ok = 1'b0;
		#1;
		chk_bit(line_en, 1'b0);
		@(negedge clk);
		power_ok = 1'b1;
		grant = 1'b0;
		settle;
		chk_bit(line_en, 1'b0);
		want_send = 1'b0;
		repeat (600) @(negedge clk);
	endtask : t_line
	task t_stretch;
		int w;
		grant = 1'b1;
		want_send = 1'b1;
		for (w = 0; w < 200 && line_en !== 1'b1; w++) @(negedge clk);
		want_send = 1'b0;
		for (w = 0; w < 1000 && line_en === 1'b1; w++) @(negedge clk);
		chk_bit(w >= 480 && w <= 520, 1'b1);
		grant = 1'b0;
		settle;
	endtask : t_stretch
	task t_rx;
		int w;
		rx_lo = 4'h1;
		rx_hi = 4'h2;
		wait_cp;
		chk_bit(cp, 1'b1);
		repeat (2) @(negedge clk);
		chk_val(rxl_d, 12'h001);
		chk_val(rxh_d, 12'h002);
		for (w = 2; w < 600 && cp === 1'b1; w++) @(negedge clk);
		chk_bit(w >= 389 && w <= 402, 1'b1);
		rx_lo = 4'h0;
		rx_hi = 4'h0;
		settle;
		chk_val(rxl_d, 12'h000);
		rx_lo = 4'h3;
		rx_hi = 4'h2;
		quiet(80);
		rx_lo = 4'h0;
		rx_hi = 4'h0;
		settle;
		rx_lo = 4'h1;
		rx_hi = 4'h2;
		@(negedge clk);
		rx_lo = 4'h0;
		rx_hi = 4'h0;
		quiet(80);
	endtask : t_rx
	task t_band;
		tone_on = 1'b1;
		for (int k = 0; k < 8; k++) begin
			tone_hz = hz_tab[k];
			settle;
			chk_val(band, {8'h00, band_tab[k]});
		end
		tone_on = 1'b0;
	endtask : t_band
	task t_test;
		rt = 1'b1;
		settle;
		chk_bit(test_mode, 1'b1);
		chk_bit(src_en, 1'b0);
		chk_bit(sync_en, 1'b0);
		want_send = 1'b1;
		settle;
		chk_bit(line_en, 1'b0);
		rx_lo = 4'h2;
		rx_hi = 4'h4;
		wait_cp;
		repeat (3) @(negedge clk);
		chk_bit(line_en, 1'b1);
		chk_val(lo_hz, 12'h302);
		chk_val(hi_hz, 12'h5c5);
		chk_val(rxl_d, 12'h000);
		c0 = 1'b1;
		c1 = 1'b1;
		settle;
		chk_bit(c0_en, 1'b1);
		chk_bit(c1_en, 1'b1);
		{rx_lo, rx_hi, c0, c1, want_send, rt} = '0;
		repeat (600) @(negedge clk);
		chk_bit(test_mode, 1'b0);
		chk_bit(src_en, 1'b1);
		chk_bit(line_en, 1'b0);
	endtask : t_test
	// characters arrive faster than they show, so they queue behind the first one
	task t_fifo;
		fork
			begin
				for (int k = 0; k < 9; k++) begin
					rx_lo = 4'h1 << (k % 4);
					rx_hi = 4'h1 << (k / 4);
					repeat (30) @(negedge clk);
					rx_lo = 4'h0;
					rx_hi = 4'h0;
					repeat (30) @(negedge clk);
				end
			end
			begin
				for (int k = 0; k < 9; k++) begin
					wait_cp;
					chk_bit(cp, 1'b1);
					repeat (2) @(negedge clk);
					chk_val(rxl_d, {8'h00, 4'h1 << (k % 4)});
					chk_val(rxh_d, {8'h00, 4'h1 << (k / 4)});
					for (int w = 0; w < 500 && cp !== 1'b0; w++) @(negedge clk);
				end
			end
		join
		quiet(80);
		chk_val(rxl_d, 12'h000);
	endtask : t_fifo

	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		{num_errors, n_checks, cyc} = '0;
		{rstn, want_send, grant, rt, c0, c1, tone_on} = '0;
		{lo_sel, hi_sel, rx_lo, rx_hi, tone_hz} = '0;
		power_ok = 1'b1;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		t_reset;
		t_tones;
		t_line;
		t_stretch;
		t_rx;
		t_band;
		t_test;
		t_fifo;
		give_verdict;
	end
endmodule : tb
